/* core/wsp_defs.vh */
// Purpose: constants for the w-cdma scramble / power-control parameter block
// Assumes: apb word-aligned byte addressing, 32-bit data
// Notes:   offsets are byte addresses
`ifndef WSP_DEFS_VH
`define WSP_DEFS_VH

// register byte offsets
`define WSP_OFF_SCR_CFG    12'h000
`define WSP_OFF_SCR_CODE   12'h004
`define WSP_OFF_TPC_WORD   12'h008
`define WSP_OFF_TPC_CFG    12'h00C
`define WSP_OFF_PWR_DATA   12'h010
`define WSP_OFF_PWR_OFS    12'h014
`define WSP_OFF_PWR_OUT    12'h018
`define WSP_OFF_DL_CFG     12'h01C
`define WSP_OFF_UL_CFG     12'h020
`define WSP_OFF_TPC_SLOT   12'h024

// scramble field widths and limits
`define WSP_CODE_W         9
`define WSP_OFS_W          4
`define WSP_SCR_W          15
`define WSP_CODE_MAX       9'h1FF
`define WSP_SCR_MAX        15'h5FFF

// scramble type encodings and added terms
`define WSP_TYPE_STD       2'h0
`define WSP_TYPE_RIGHT     2'h1
`define WSP_TYPE_LEFT      2'h2
`define WSP_ADD_RIGHT      15'h4000
`define WSP_ADD_LEFT       15'h2000

// power-control word
`define WSP_TPC_BITS       15
`define WSP_TPC_FIELD_W    16

// user data patterns
`define WSP_DATA_RANDOM    2'h0
`define WSP_DATA_PN9       2'h1
`define WSP_DATA_PATTERN   2'h2

// reset values
`define WSP_TPC_RESET      15'h5555
`define WSP_NTPC_RESET     5'h02
`define WSP_NFBI_RESET     2'h0
`define WSP_CHANS_RESET    10'h001

`endif

/* core/wsp_params.v */
// Purpose: w-cdma channel parameter engine behind an apb slave
// Assumes: single clock pclk, 50 MHz; async active-low presetn
// Notes:   scramble code, tpc slot fields, control-field powers, data bits
`timescale 1ns/100ps
`include "wsp_defs.vh"

// Summary of operation
// - tpc entry is a 15-bit word
// - msb maps to slot 0, lsb slot 14
// - slot bit replicated across tpc field width
// - one means power up, zero power down
// - control power equals data power plus offset
// - scramble code is 16*code plus offset plus type
// - any field change recomputes the code
// - scramble code stays within 0 to 24575
// - offset 0..15; zero primary, else secondary
// - type adds 0, 16384 or 8192
// - standard type covers codes 0 to 8191
// - up to 512 downlink traffic channels
// - user data random, pn9 or 8-bit pattern
// - uplink channel 2 i/q; 3..6 alternate
// - uplink tfci disable, variable fbi bits
// - unused downlink tfci bits become dtx
module wsp_params
#(
    parameter MAX_CHANS = 512,            // downlink traffic channel limit
    parameter NTPC_MAX  = 16              // widest tpc field in bits
)
(
    // apb clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // frame field outputs
    input  wire        slot_adv,          // one-cycle pulse, next timeslot
    output reg  [14:0] scr_code,          // resulting scrambling code
    output reg  [15:0] tpc_field,         // current slot tpc field, low bits used
    output reg         tpc_up,            // current slot asks for more power
    output reg  [3:0]  slot_idx,          // current timeslot 0..14
    output reg  [15:0] tfci_pwr,          // tfci power, signed centi-db
    output reg  [15:0] tpc_pwr,           // tpc power, signed centi-db
    output reg  [15:0] pilot_pwr,         // pilot power, signed centi-db
    output reg         tfci_dtx,          // tfci positions carry dtx
    output reg         data_bit,          // user data bit stream
    output reg  [5:0]  ul_branch_q        // per uplink data channel 1..6, 1 = q
);

// ----------------------------------------------------------------
// software visible state
// ----------------------------------------------------------------
reg  [8:0]  code_in;                      // scramble code field
reg  [3:0]  ofs_in;                       // scramble offset field
reg  [1:0]  type_in;                      // scramble type field
reg  [14:0] tpc_word;                     // power-control word
reg  [4:0]  ntpc;                         // tpc field width
reg  [15:0] data_pwr;                     // data channel power
reg  [7:0]  ofs_tfci;                     // signed offsets, centi-db
reg  [7:0]  ofs_tpc;
reg  [7:0]  ofs_pilot;
reg  [1:0]  data_mode;                    // user data source
reg  [7:0]  data_pat;                     // repeating pattern
reg         dl_tfci_on;                   // downlink tfci bits used
reg  [9:0]  dl_chans;                     // traffic channel count
reg         ul_ch2_i;                     // uplink channel 2 on i
reg         ul_tfci_on;                   // uplink tfci field enabled
reg  [1:0]  ul_nfbi;                      // uplink fbi bit count
reg  [7:0]  ul_tfc;                       // uplink tfc field value
reg  [1:0]  ul_fbi;                       // uplink fbi field value
reg         data_step;                    // advance data generator
reg  [8:0]  pn9;                          // pn9 shift register
reg  [15:0] lfsr;                         // random data source
reg  [2:0]  pat_idx;                      // pattern bit index

wire        wr_en;                        // write access phase
wire        rd_en;                        // read access phase
wire        mapped;                       // address decodes
wire [14:0] next_scr;                     // next scrambling code
wire        tpc_bit;                      // current slot's tpc bit

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// control power: data power plus a sign-extended offset
function [15:0] add_ofs;
    input [15:0] base;
    input [7:0]  ofs;
    begin
        add_ofs = base + {{8{ofs[7]}}, ofs};
    end
endfunction

// scramble term chosen by the type field
function [14:0] type_term;
    input [1:0] t;
    begin
        case (t)
            `WSP_TYPE_RIGHT: type_term = `WSP_ADD_RIGHT;
            `WSP_TYPE_LEFT:  type_term = `WSP_ADD_LEFT;
            default:         type_term = 15'h0000;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
assign pready  = 1'b1;                    // zero-wait slave
assign wr_en   = psel & penable & pwrite;
assign rd_en   = psel & penable & ~pwrite;
assign mapped  = (paddr <= `WSP_OFF_TPC_SLOT) && (paddr[1:0] == 2'h0);
assign pslverr = psel & penable & ~mapped;

// ----------------------------------------------------------------
// scramble code
// ----------------------------------------------------------------
// n = 16*i + k + m
// nonzero offset lands between the multiples of 16
// type term from the type field
assign next_scr = {2'h0, code_in, 4'h0} + {11'h000, ofs_in} + type_term(type_in);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        scr_code <= 15'h0000;
    else if (next_scr > `WSP_SCR_MAX)
        scr_code <= `WSP_SCR_MAX;
    else
        scr_code <= next_scr;
end

// ----------------------------------------------------------------
// register writes
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        code_in    <= 9'h000;
        ofs_in     <= 4'h0;
        type_in    <= `WSP_TYPE_STD;
        tpc_word   <= `WSP_TPC_RESET;
        ntpc       <= `WSP_NTPC_RESET;
        data_pwr   <= 16'h0000;
        ofs_tfci   <= 8'h00;
        ofs_tpc    <= 8'h00;
        ofs_pilot  <= 8'h00;
        data_mode  <= `WSP_DATA_RANDOM;
        data_pat   <= 8'h00;
        dl_tfci_on <= 1'b1;
        dl_chans   <= `WSP_CHANS_RESET;
        ul_ch2_i   <= 1'b0;
        ul_tfci_on <= 1'b1;
        ul_nfbi    <= `WSP_NFBI_RESET;
        ul_tfc     <= 8'h00;
        ul_fbi     <= 2'h0;
    end
    else if (wr_en)
    begin
        case (paddr)
            `WSP_OFF_SCR_CFG:
            begin
                // code entry limited by software; upper bits dropped
                code_in <= pwdata[8:0];
                ofs_in  <= pwdata[19:16];
                // reserved type code falls back to standard
                type_in <= (pwdata[25:24] == 2'h3) ? `WSP_TYPE_STD : pwdata[25:24];
            end
            // entry taken as a 15-bit binary word
            `WSP_OFF_TPC_WORD: tpc_word <= pwdata[14:0];
            `WSP_OFF_TPC_CFG:
            begin
                // width 1..NTPC_MAX, zero treated as one
                if (pwdata[4:0] == 5'h00)
                    ntpc <= 5'h01;
                else if (pwdata[4:0] > NTPC_MAX)
                    ntpc <= NTPC_MAX[4:0];
                else
                    ntpc <= pwdata[4:0];
            end
            `WSP_OFF_PWR_DATA: data_pwr <= pwdata[15:0];
            `WSP_OFF_PWR_OFS:
            begin
                ofs_tfci  <= pwdata[7:0];
                ofs_tpc   <= pwdata[15:8];
                ofs_pilot <= pwdata[23:16];
            end
            `WSP_OFF_DL_CFG:
            begin
                data_mode  <= (pwdata[1:0] == 2'h3) ? `WSP_DATA_RANDOM : pwdata[1:0];
                dl_tfci_on <= pwdata[2];
                data_pat   <= pwdata[15:8];
                if (pwdata[25:16] == 10'h000)
                    dl_chans <= 10'h001;
                else if (pwdata[25:16] > MAX_CHANS)
                    dl_chans <= MAX_CHANS[9:0];
                else
                    dl_chans <= pwdata[25:16];
            end
            `WSP_OFF_UL_CFG:
            begin
                // tfc, fbi editable, tfci off, fbi count
                ul_ch2_i   <= pwdata[0];
                ul_tfci_on <= pwdata[1];
                ul_nfbi    <= (pwdata[3:2] == 2'h3) ? 2'h2 : pwdata[3:2];
                ul_tfc     <= pwdata[15:8];
                ul_fbi     <= pwdata[17:16];
            end
            default:
            begin
                // read-only or unmapped: no effect
            end
        endcase
    end
end

// ----------------------------------------------------------------
// timeslot and tpc field
// ----------------------------------------------------------------
// slot counter wraps 14 to 0
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        slot_idx <= 4'h0;
    else if (slot_adv)
        slot_idx <= (slot_idx == 4'hE) ? 4'h0 : slot_idx + 4'h1;
end

// slot s takes word bit 14-s
assign tpc_bit = tpc_word[4'hE - slot_idx];

// bit repeated over the field width
// one raises power, zero lowers it
always @(posedge pclk or negedge presetn)
begin : tpc_proc
    integer j;
    if (!presetn)
    begin
        tpc_field <= 16'h0000;
        tpc_up    <= 1'b0;
    end
    else
    begin
        tpc_up <= tpc_bit;
        for (j = 0; j < 16; j = j + 1)
            tpc_field[j] <= tpc_bit & (j < ntpc);
    end
end

// ----------------------------------------------------------------
// control powers and channel options
// ----------------------------------------------------------------
// only control fields get offsets
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tfci_pwr    <= 16'h0000;
        tpc_pwr     <= 16'h0000;
        pilot_pwr   <= 16'h0000;
        tfci_dtx    <= 1'b0;
        ul_branch_q <= 6'h00;
    end
    else
    begin
        tfci_pwr    <= add_ofs(data_pwr, ofs_tfci);
        tpc_pwr     <= add_ofs(data_pwr, ofs_tpc);
        pilot_pwr   <= add_ofs(data_pwr, ofs_pilot);
        tfci_dtx    <= ~dl_tfci_on;
        // ch1 on i; ch2 per choice; then alternate
        ul_branch_q <= {~ul_ch2_i, ul_ch2_i, ~ul_ch2_i, ul_ch2_i, ~ul_ch2_i, 1'b0};
    end
end

// ----------------------------------------------------------------
// user data generator
// ----------------------------------------------------------------
// random, pn9 or 8-bit repeating pattern
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pn9       <= 9'h1FF;
        lfsr      <= 16'hACE1;
        pat_idx   <= 3'h7;
        data_bit  <= 1'b0;
        data_step <= 1'b0;
    end
    else
    begin
        data_step <= 1'b1;
        if (data_step)
        begin
            pn9     <= {pn9[7:0], pn9[8] ^ pn9[4]};
            lfsr    <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            pat_idx <= pat_idx - 3'h1;
            case (data_mode)
                `WSP_DATA_PN9:     data_bit <= pn9[8];
                `WSP_DATA_PATTERN: data_bit <= data_pat[pat_idx];
                default:           data_bit <= lfsr[15];
            endcase
        end
    end
end

// ----------------------------------------------------------------
// register reads
// ----------------------------------------------------------------
always @*
begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
        case (paddr)
            `WSP_OFF_SCR_CFG:  prdata = {6'h00, type_in, 4'h0, ofs_in, 7'h00, code_in};
            `WSP_OFF_SCR_CODE: prdata = {17'h00000, scr_code};
            `WSP_OFF_TPC_WORD: prdata = {17'h00000, tpc_word};
            `WSP_OFF_TPC_CFG:  prdata = {27'h0000000, ntpc};
            `WSP_OFF_PWR_DATA: prdata = {16'h0000, data_pwr};
            `WSP_OFF_PWR_OFS:  prdata = {8'h00, ofs_pilot, ofs_tpc, ofs_tfci};
            `WSP_OFF_PWR_OUT:  prdata = {tpc_pwr, tfci_pwr};
            `WSP_OFF_DL_CFG:   prdata = {6'h00, dl_chans, data_pat, 5'h00, dl_tfci_on, data_mode};
            `WSP_OFF_UL_CFG:   prdata = {14'h0000, ul_fbi, ul_tfc, 4'h0, ul_nfbi, ul_tfci_on, ul_ch2_i};
            `WSP_OFF_TPC_SLOT: prdata = {11'h000, tpc_up, slot_idx, tpc_field};
            default:           prdata = 32'h0000_0000;
        endcase
    end
end

endmodule

/* verification/wsp_params_assertions.sv */
// Purpose: port-level concurrent checks on the parameter block
// Assumes: one domain, pclk, presetn async active low
// Notes:   outputs derived from a write show two edges after it
`timescale 1ns/100ps
`include "wsp_defs.vh"
module wsp_params_checker
#(
    parameter MAX_CHANS = 512,              // traffic channel limit
    parameter NTPC_MAX  = 16                // widest tpc field
)
(
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb slave
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    // frame fields
    input wire [14:0] scr_code,
    input wire [15:0] tpc_field,
    input wire        tpc_up,
    input wire [3:0]  slot_idx,
    input wire [15:0] tfci_pwr,
    input wire [15:0] tpc_pwr,
    input wire        tfci_dtx,
    input wire [5:0]  ul_branch_q
);
    // ----
    // helpers
    // ----
    wire wr    = psel && penable && pwrite && pready;   // write taken here
    wire w_scr = wr && paddr == `WSP_OFF_SCR_CFG;       // scramble config
    wire w_ofs = wr && paddr == `WSP_OFF_PWR_OFS;       // power offsets
    wire w_dl  = wr && paddr == `WSP_OFF_DL_CFG;        // downlink config
    wire w_ul  = wr && paddr == `WSP_OFF_UL_CFG;        // uplink config
    wire bad   = paddr > `WSP_OFF_TPC_SLOT || paddr[1:0] != 2'h0;  // unmapped
    // code from a config word; type 3 acts as standard
    function [14:0] scr_of(input [31:0] d);
        scr_of = {d[8:0], 4'h0} + d[19:16] + (d[25:24] == 2'h1 ? `WSP_ADD_RIGHT :
                 (d[25:24] == 2'h2 ? `WSP_ADD_LEFT : 15'h0000));
    endfunction
    // sign extension of an 8-bit offset
    function [15:0] sx(input [7:0] b);
        sx = {{8{b[7]}}, b};
    endfunction
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // properties
    // ----
    AST_SCR_CALC: assert property (w_scr |-> ##2 scr_code == scr_of($past(pwdata, 2)))
        else $error("scramble code does not follow its fields");
    AST_SCR_RANGE: assert property (scr_code <= `WSP_SCR_MAX)
        else $error("scramble code above its range");
    AST_SLOT_RANGE: assert property (slot_idx <= 4'hE)
        else $error("timeslot index beyond the frame");
    AST_TPC_REP: assert property ((tpc_field & (tpc_field + 16'h0001)) == 16'h0000)
        else $error("tpc field is not a run of copies");
    AST_TPC_DIR: assert property (tpc_up ? tpc_field != 16'h0000 : tpc_field == 16'h0000)
        else $error("tpc field disagrees with direction");
    AST_PWR_OFS: assert property (w_ofs |-> ##2 tpc_pwr - tfci_pwr == sx($past(pwdata[15:8], 2)) - sx($past(pwdata[7:0], 2)))
        else $error("control powers not offset as written");
    AST_DTX: assert property (w_dl |-> ##2 tfci_dtx == !$past(pwdata[2], 2))
        else $error("dtx flag does not follow tfci enable");
    AST_UL_CH2: assert property (w_ul |-> ##2 ul_branch_q[1] == !$past(pwdata[0], 2))
        else $error("second channel branch wrong");
    AST_UL_ALT: assert property ($past(presetn, 2) |-> ul_branch_q == 6'h2A || ul_branch_q == 6'h14)
        else $error("uplink channels do not alternate");
    AST_SLVERR: assert property (psel && penable |-> pslverr == bad)
        else $error("slave error does not match address");
endmodule
bind wsp_params wsp_params_checker #(.MAX_CHANS(MAX_CHANS), .NTPC_MAX(NTPC_MAX)) wsp_params_checker_inst
    (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .scr_code,
     .tpc_field, .tpc_up, .slot_idx, .tfci_pwr, .tpc_pwr, .tfci_dtx, .ul_branch_q);

/* verification/wsp_params_tb.sv */
// Purpose: self-checking bench for the parameter block
// Assumes: bench is apb master, drives at pclk rising edge
// Notes:   expectations worked out from the field values written
`timescale 1ns/100ps
`include "wsp_defs.vh"
module wsp_params_tb;
    // ----
    // signals
    // ----
    reg         pclk     = 1'b0;     // apb clock
    reg         presetn  = 1'b0;     // async reset, active low
    reg         psel     = 1'b0;
    reg         penable  = 1'b0;
    reg         pwrite   = 1'b0;
    reg  [11:0] paddr    = 12'h000;
    reg  [31:0] pwdata   = 32'h0;
    reg         slot_adv = 1'b0;     // timeslot strobe
    wire [31:0] prdata;
    wire        pready, pslverr, tpc_up, tfci_dtx, data_bit;
    wire [14:0] scr_code;
    wire [15:0] tpc_field, tfci_pwr, tpc_pwr, pilot_pwr;
    wire [3:0]  slot_idx;
    wire [5:0]  ul_branch_q;
    reg  [31:0] rd;                  // last read data
    reg         se;                  // last slave error
    integer     err_count = 0;
    integer     n_checks  = 0;
    integer     i, p, k;
    // scramble configs {type, ofs, code} and codes
    // code entries within 0..511
    reg  [31:0] sc_cfg [8] = '{32'h0000_0006, 32'h0007_0008, 32'h0200_0006, 32'h0107_0008,
                              32'h0000_01FF, 32'h000F_01FF, 32'h010F_01FF, 32'h030F_01FF};
    reg  [14:0] sc_exp [8] = '{15'h0060, 15'h0087, 15'h2060, 15'h4087, 15'h1FF0, 15'h1FFF, 15'h5FFF, 15'h1FFF};
    // tpc words, field widths and expected masks
    reg  [14:0] tw [3] = '{15'h7F80, 15'h00FF, 15'h4001};
    reg  [31:0] tn [3] = '{32'h2, 32'h10, 32'h0};
    reg  [15:0] tm [3] = '{16'h0003, 16'hFFFF, 16'h0001};
    wsp_params wsp_params_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .slot_adv, .scr_code, .tpc_field, .tpc_up, .slot_idx, .tfci_pwr, .tpc_pwr,
        .pilot_pwr, .tfci_dtx, .data_bit, .ul_branch_q);
    // free-running clock, 20 ns
    initial
        forever #10 pclk = ~pclk;
    // ----
    // tasks
    // ----
    task complete_run;
        begin
            $display("checks %0d errors %0d", n_checks, err_count);
            if (err_count == 0 && n_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one apb transfer, then an idle edge
    task apb(input [11:0] a, input w, input [31:0] d);
        integer n;
        begin
            psel    <= 1'b1;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            n = 0;
            while (pready !== 1'b1)
            begin
                n = n + 1;
                if (n > 20)
                begin
                    err_count = err_count + 1;
                    complete_run;
                end
                @(posedge pclk);
            end
            rd = prdata;
            se = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rdc(input [11:0] a, input [31:0] exp);
        begin
            apb(a, 1'b0, 32'h0);
            chk(rd, exp);
        end
    endtask
    // one timeslot strobe, field lands two edges on
    task pulse;
        begin
            slot_adv <= 1'b1;
            @(posedge pclk);
            slot_adv <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
    // ----
    // scenarios
    // ----
    task t_scr;
        begin
            for (i = 0; i < 8; i = i + 1)
            begin
                apb(`WSP_OFF_SCR_CFG, 1'b1, sc_cfg[i]);
                @(posedge pclk);
                chk(scr_code, sc_exp[i]);
                rdc(`WSP_OFF_SCR_CODE, sc_exp[i]);
            end
            apb(`WSP_OFF_SCR_CODE, 1'b1, 32'h0);
            rdc(`WSP_OFF_SCR_CODE, 32'h1FFF);
        end
    endtask
    task t_tpc;
        begin
            for (p = 0; p < 3; p = p + 1)
            begin
                apb(`WSP_OFF_TPC_WORD, 1'b1, tw[p]);
                apb(`WSP_OFF_TPC_CFG, 1'b1, tn[p]);
                // new width reaches the field one edge on
                @(posedge pclk);
                for (k = 0; k < 15 && slot_idx !== 4'h0; k = k + 1)
                    pulse;
                for (i = 0; i < 15; i = i + 1)
                begin
                    chk(slot_idx, i);
                    chk(tpc_up, tw[p][14 - i]);
                    chk(tpc_field, {16{tw[p][14 - i]}} & tm[p]);
                    pulse;
                end
            end
        end
    endtask
    task t_pwr;
        begin
            apb(`WSP_OFF_PWR_DATA, 1'b1, 32'h0000_FFC4);
            apb(`WSP_OFF_PWR_OFS, 1'b1, 32'h000A_E214);
            @(posedge pclk);
            chk(pilot_pwr, 16'hFFCE);
            rdc(`WSP_OFF_PWR_OUT, 32'hFFA6_FFD8);
        end
    endtask
    // kind: 0/1 constant pattern, 2 random, 3 pn9
    task t_dl(input [31:0] cfg, input dtx, input [1:0] kind);
        reg [39:0] h;                // data bits seen, oldest in bit 0
        begin
            apb(`WSP_OFF_DL_CFG, 1'b1, cfg);
            repeat (4) @(posedge pclk);
            chk(tfci_dtx, dtx);
            k = 0;
            for (i = 0; i < 40; i = i + 1)
            begin
                @(posedge pclk);
                h[i] = data_bit;
                if (kind < 2'h2)
                    chk(data_bit, kind);
                else if (i > 0 && h[i] !== h[i - 1])
                    k = k + 1;
            end
            // pn9 obeys s(n) = s(n-9) xor s(n-5)
            if (kind == 2'h3)
                for (i = 9; i < 40; i = i + 1)
                    chk(h[i], h[i - 9] ^ h[i - 5]);
            else if (kind == 2'h2)
                chk(k > 0, 1'b1);
        end
    endtask
    task t_ul;
        begin
            apb(`WSP_OFF_UL_CFG, 1'b1, 32'h0003_A50C);
            @(posedge pclk);
            chk(ul_branch_q, 6'h2A);
            rdc(`WSP_OFF_UL_CFG, 32'h0003_A508);
            apb(`WSP_OFF_UL_CFG, 1'b1, 32'h0000_0007);
            @(posedge pclk);
            chk(ul_branch_q, 6'h14);
            rdc(`WSP_OFF_UL_CFG, 32'h0000_0007);
        end
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`WSP_OFF_TPC_WORD, 32'h5555);
        chk(scr_code, 15'h0000);
        t_scr;
        t_tpc;
        t_pwr;
        t_dl(32'h0001_0002, 1'b1, 2'h0);
        t_dl(32'h0001_FF06, 1'b0, 2'h1);
        t_dl(32'h0001_0004, 1'b0, 2'h2);
        t_dl(32'h0001_0005, 1'b0, 2'h3);
        t_dl(32'h0001_0007, 1'b0, 2'h2);
        apb(`WSP_OFF_DL_CFG, 1'b1, 32'h0258_0004);
        rdc(`WSP_OFF_DL_CFG, 32'h0200_0004);
        t_ul;
        apb(12'h028, 1'b1, 32'hFFFF_FFFF);
        chk(se, 1'b1);
        rdc(`WSP_OFF_TPC_SLOT + 12'h4, 32'h0);
        chk(se, 1'b1);
        complete_run;
    end
endmodule
